//--- include/pm_timer_pkg.sv
// Package with constants and carrier types for the power management timer
package pm_timer_pkg;
    localparam int COUNT_W = 24;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 24'h000000;
    localparam logic [COUNT_W-1:0] COUNT_ONE = 24'h000001;
    localparam int CARRY_BIT = 23;
    localparam int ADDR_W = 16;
    localparam int OFS_W = 4;
    // Byte offsets of the count registers from the base
    localparam logic [OFS_W-1:0] OFS_COUNT_LOW = 4'h8;
    localparam logic [OFS_W-1:0] OFS_COUNT_MID = 4'h9;
    localparam logic [OFS_W-1:0] OFS_COUNT_HIGH = 4'ha;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [ADDR_W-1:0] BASE_RESET = 16'h0000;

    // One host I/O access, presented for one cycle
    typedef struct packed {
        logic rd;
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
    } io_req_s;

    // Interrupt routing controls coming from the power management block
    typedef struct packed {
        logic timer_event_enable;
        logic sci_route_select;
        logic smi_enable;
    } pm_route_s;

    // Registered view of the timer for the rest of the device
    typedef struct packed {
        logic [COUNT_W-1:0] timer_count_value;
        logic timer_carry_status;
    } timer_state_s;
endpackage

//--- src/pm_free_running_timer.sv
// Free running 24-bit power management timer with byte read port
`timescale 1ns/1ps

module pm_free_running_timer
    import pm_timer_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic master_reset,
    input wire logic input_clock_pin,
    input wire logic working_state,
    input wire logic [ADDR_W-1:0] pm_base_config,
    input wire io_req_s io_req,
    input wire pm_route_s pm_route,
    input wire logic timer_carry_status_clear,
    output logic [7:0] io_rdata,
    output logic io_rvalid,
    output timer_state_s timer_state,
    output logic sci_request,
    output logic smi_request
);

    // Hit test of one timer byte relative to the configured base
    function automatic logic hit(input logic [ADDR_W-1:0] addr,
                                 input logic [ADDR_W-1:0] base,
                                 input logic [OFS_W-1:0] ofs);
        logic [ADDR_W-1:0] target;
        target = base + {{(ADDR_W-OFS_W){1'b0}}, ofs};
        return addr == target;
    endfunction

    // Pin sampling chain; the seen flags mark stages that hold
    // a real pin sample rather than their reset value, since the
    // pin may idle at either level while the timing clock is stopped
    logic sync1_ff, nxt_sync1;
    logic sync2_ff, nxt_sync2;
    logic sync3_ff, nxt_sync3;
    logic seen1_ff, nxt_seen1;
    logic seen2_ff, nxt_seen2;
    logic seen3_ff, nxt_seen3;

    // Count and carry status state
    logic [COUNT_W-1:0] count_ff, nxt_count;
    logic status_ff, nxt_status;

    // Registered read answer
    logic [7:0] rdata_ff, nxt_rdata;
    logic rvalid_ff, nxt_rvalid;

    // Registered interrupt pulses
    logic sci_ff, nxt_sci;
    logic smi_ff, nxt_smi;

    // Decoded strobes shared between the groups
    logic pin_rise;
    logic tick;
    logic carry_flip;
    logic status_set;
    logic status_clear;
    logic raise;
    logic hit_low, hit_mid, hit_high;
    logic hit_any;

    // Next values of the pin chain; only the second stage reads the first
    always_comb begin
        nxt_sync1 = input_clock_pin;
        nxt_sync2 = sync1_ff;
        nxt_sync3 = sync2_ff;
        nxt_seen1 = 1'b1;
        nxt_seen2 = seen1_ff;
        nxt_seen3 = seen2_ff;
    end

    // Pin chain registers; reset empties the seen flags
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            sync3_ff <= 1'b0;
            seen1_ff <= 1'b0;
            seen2_ff <= 1'b0;
            seen3_ff <= 1'b0;
        end else begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
            sync3_ff <= nxt_sync3;
            seen1_ff <= nxt_seen1;
            seen2_ff <= nxt_seen2;
            seen3_ff <= nxt_seen3;
        end
    end

    // Rising pin edge, taken only once all three stages hold real
    // samples: a pin idling high at reset would otherwise look like
    // an edge and add a false count
    assign pin_rise = sync2_ff & ~sync3_ff & seen3_ff;

    // No edge means no step, so a stopped pin freezes the count.
    // Pin phases shorter than one system cycle may be missed.
    assign tick = pin_rise & working_state;

    // Count next value; master reset wins over a step
    always_comb begin
        nxt_count = count_ff;
        if (master_reset) begin
            nxt_count = COUNT_RESET;
        end else if (tick) begin
            nxt_count = count_ff + COUNT_ONE;
        end
    end

    // Count register; wraps from all ones back to zero
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            count_ff <= COUNT_RESET;
        end else begin
            count_ff <= nxt_count;
        end
    end

    // Bit 23 change in either direction, seen one cycle early
    assign carry_flip = nxt_count[CARRY_BIT] ^ count_ff[CARRY_BIT];

    // Set and clear requests of the status flag; a master reset that
    // drops bit 23 is not a flip that sets the flag
    assign status_set = carry_flip & ~master_reset;
    assign status_clear = timer_carry_status_clear | master_reset;

    // Set beats clear so a flip in the clear cycle is kept
    always_comb begin
        nxt_status = status_ff;
        if (status_set) begin
            nxt_status = 1'b1;
        end else if (status_clear) begin
            nxt_status = 1'b0;
        end
    end

    // Status register; logic outside reads and clears it
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            status_ff <= 1'b0;
        end else begin
            status_ff <= nxt_status;
        end
    end

    // One pulse per setting of the flag, not a level on the flag, so
    // the status logic outside decides how long an interrupt stays
    always_comb begin
        raise = status_set & pm_route.timer_event_enable;
        nxt_sci = raise & pm_route.sci_route_select;
        nxt_smi = raise & ~pm_route.sci_route_select
                  & pm_route.smi_enable;
    end

    // Interrupt pulse registers; each pulse lasts one cycle
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            sci_ff <= 1'b0;
            smi_ff <= 1'b0;
        end else begin
            sci_ff <= nxt_sci;
            smi_ff <= nxt_smi;
        end
    end

    // Full 16-bit compare of base plus offset; the sum wraps, so a
    // base near the top of I/O space places the bytes near zero
    assign hit_low = hit(io_req.addr, pm_base_config, OFS_COUNT_LOW);
    assign hit_mid = hit(io_req.addr, pm_base_config, OFS_COUNT_MID);
    assign hit_high = hit(io_req.addr, pm_base_config, OFS_COUNT_HIGH);
    assign hit_any = hit_low | hit_mid | hit_high;

    // Read mux on the live count; bytes are not latched together,
    // so software reading across a carry may see a torn value
    always_comb begin
        nxt_rdata = BYTE_ZERO;
        nxt_rvalid = 1'b0;
        if (io_req.rd) begin
            if (hit_low) begin
                nxt_rdata = count_ff[7:0];
            end else if (hit_mid) begin
                nxt_rdata = count_ff[15:8];
            end else if (hit_high) begin
                nxt_rdata = count_ff[23:16];
            end
            nxt_rvalid = hit_any;
        end
        // Writes have no path into any state
    end

    // Read answer registers; data falls back to zero after one cycle
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rdata_ff <= BYTE_ZERO;
            rvalid_ff <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    // Outputs straight from flip-flops, so the rest of the device
    // never sees a glitch from the decode or the adder
    assign io_rdata = rdata_ff;
    assign io_rvalid = rvalid_ff;
    assign timer_state.timer_count_value = count_ff;
    assign timer_state.timer_carry_status = status_ff;
    assign sci_request = sci_ff;
    assign smi_request = smi_ff;

endmodule

//--- testbench/pm_timer_sva.sv
// Checker for the power management timer ports
`timescale 1ns/1ps
module pm_timer_sva
    import pm_timer_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic master_reset,
    input wire io_req_s io_req,
    input wire pm_route_s pm_route,
    input wire logic [ADDR_W-1:0] pm_base_config,
    input wire logic [7:0] io_rdata,
    input wire logic io_rvalid,
    input wire timer_state_s timer_state,
    input wire logic sci_request,
    input wire logic smi_request
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // Offset wraps below base, so low addresses hit only when base plus offset wraps past the top
    wire [ADDR_W-1:0] ofs = io_req.addr - pm_base_config;
    wire hit = io_req.rd && ofs >= 16'h0008 && ofs <= 16'h000a;
    wire [COUNT_W-1:0] cnt = timer_state.timer_count_value;
    sequence s_hit;
        hit;
    endsequence
    // Top bit moved by counting, not by a master reset
    sequence s_flip;
        $changed(cnt[CARRY_BIT]) && !$past(master_reset);
    endsequence
    a_read_answer: assert property (s_hit |=> io_rvalid)
        else $error("read got no answer");
    a_no_stray: assert property (!hit |=> !io_rvalid
        && io_rdata == BYTE_ZERO)
        else $error("stray read answer");
    a_low_byte: assert property (hit && ofs == 16'h0008
        |=> io_rdata == $past(cnt[7:0]))
        else $error("low byte not live count");
    a_mid_byte: assert property (hit && ofs == 16'h0009
        |=> io_rdata == $past(cnt[15:8]))
        else $error("mid byte not live count");
    a_high_byte: assert property (hit && ofs == 16'h000a
        |=> io_rdata == $past(cnt[23:16]))
        else $error("high byte not live count");
    a_count_step: assert property ($changed(cnt)
        && !$past(master_reset) |-> cnt == $past(cnt) + COUNT_ONE)
        else $error("count moved by other than one");
    a_mr_clear: assert property (master_reset |=> cnt == COUNT_RESET
        && !timer_state.timer_carry_status)
        else $error("master reset did not clear");
    a_carry_status: assert property (s_flip
        |-> timer_state.timer_carry_status)
        else $error("top bit flip did not set status");
    // Route levels are taken from the cycle that launched the pulse
    a_sci_cause: assert property (sci_request
        |-> $changed(cnt[CARRY_BIT])
        && $past(pm_route.timer_event_enable)
        && $past(pm_route.sci_route_select))
        else $error("sci without cause");
    a_sci_raise: assert property ($changed(cnt[CARRY_BIT])
        && !$past(master_reset) && $past(pm_route.timer_event_enable)
        && $past(pm_route.sci_route_select) |-> sci_request)
        else $error("flip raised no sci");
    a_smi_route: assert property (smi_request
        |-> $changed(cnt[CARRY_BIT])
        && !$past(pm_route.sci_route_select)
        && $past(pm_route.smi_enable))
        else $error("smi on wrong route");
endmodule
bind pm_free_running_timer pm_timer_sva i_pm_timer_sva (.*);

//--- testbench/pm_free_running_timer_tb.sv
// Self-checking bench for the power management timer
`timescale 1ns/1ps
module pm_free_running_timer_tb;
    import pm_timer_pkg::*;
    logic clk_sys = 0, rstn = 0, master_reset = 0, pin = 0, work = 1;
    logic [ADDR_W-1:0] base = 16'h0400;
    io_req_s req = '0;
    pm_route_s route = 3'h7;
    logic [7:0] rdata;
    logic rvalid, sci, smi;
    logic clr = 0;
    timer_state_s st;
    int err_total = 0, checks = 0;
    pm_free_running_timer i_pm_free_running_timer (.clk_sys(clk_sys),
        .rstn(rstn), .master_reset(master_reset), .input_clock_pin(pin),
        .working_state(work), .pm_base_config(base), .io_req(req),
        .pm_route(route), .timer_carry_status_clear(clr),
        .io_rdata(rdata), .io_rvalid(rvalid), .timer_state(st),
        .sci_request(sci), .smi_request(smi));
    // Free running system clock
    initial forever #5 clk_sys = ~clk_sys;
    task automatic tally_and_finish;
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    // Three cycles each phase, above the one-cycle sync minimum
    task automatic tick(input int n);
        repeat (n) begin
            pin = 1;
            repeat (3) @(negedge clk_sys);
            pin = 0;
            repeat (3) @(negedge clk_sys);
        end
    endtask
    // One-cycle strobe, answer checked while it stands, then one idle
    // cycle so that back-to-back calls never touch req twice at once
    task automatic io(input logic w, input logic [3:0] o,
                      input logic [7:0] e, input logic h);
        req = '{rd: !w, wr: w, addr: base + o, wdata: 8'hff};
        @(negedge clk_sys);
        req = '0;
        if (!w) begin
            chk(rvalid, h);
            chk(rdata, e);
        end
        @(negedge clk_sys);
        chk(rvalid, 1'b0);
    endtask
    task automatic rd3(input logic [23:0] v);
        io(1'b0, 4'h8, v[7:0], 1'b1);
        io(1'b0, 4'h9, v[15:8], 1'b1);
        io(1'b0, 4'ha, v[23:16], 1'b1);
    endtask
    task automatic t_count;
        tick(5);
        rd3(24'h000005);
        io(1'b0, 4'hb, 8'h00, 1'b0);
    endtask
    task automatic t_write;
        for (int o = 8; o < 11; o++) io(1'b1, o[3:0], 8'h00, 1'b0);
        rd3(24'h000005);
    endtask
    task automatic t_hold;
        repeat (40) @(negedge clk_sys);
        rd3(24'h000005);
        tick(3);
        rd3(24'h000008);
    endtask
    task automatic t_idle;
        work = 0;
        tick(2);
        work = 1;
        rd3(24'h000008);
    endtask
    // Bit 23 needs 2^23 ticks, far past this run: flag and pulses stay low
    task automatic t_quiet;
        clr = 1;
        @(negedge clk_sys);
        clr = 0;
        chk(st.timer_carry_status, 1'b0);
        chk(sci, 1'b0);
        chk(smi, 1'b0);
        rd3(24'h000008);
    endtask
    task automatic t_mr;
        master_reset = 1;
        @(negedge clk_sys);
        master_reset = 0;
        rd3(24'h000000);
        tick(2);
        rd3(24'h000002);
    endtask
    // Second system reset in mid-run clears count and read answer
    task automatic t_rst;
        rstn = 0;
        repeat (5) @(negedge clk_sys);
        rstn = 1;
        chk(st.timer_count_value, COUNT_RESET);
        chk(rvalid, 1'b0);
        rd3(24'h000000);
    endtask
    // Watchdog, far beyond the roughly 190 cycles needed
    initial begin
        repeat (5000) @(posedge clk_sys);
        err_total++;
        tally_and_finish;
    end
    initial begin
        repeat (5) @(negedge clk_sys);
        rstn = 1;
        @(negedge clk_sys);
        chk(st.timer_count_value, COUNT_RESET);
        t_count;
        t_write;
        t_hold;
        t_idle;
        t_quiet;
        t_mr;
        t_rst;
        tally_and_finish;
    end
endmodule
